// >>> logic/ppei_regs.vh
// register offsets, field layouts and reset values of the port pin interrupt unit
`ifndef PPEI_REGS_VH
`define PPEI_REGS_VH

`define PPEI_PORTS         2
`define PPEI_PINS          8
`define PPEI_ADDR_W        12

`define PPEI_OFF_MODE_LO   12'h000
`define PPEI_OFF_MODE_HI   12'h004
`define PPEI_OFF_STAT0     12'h008
`define PPEI_OFF_STAT1     12'h00C
`define PPEI_OFF_MASK0     12'h010
`define PPEI_OFF_MASK1     12'h014
`define PPEI_OFF_INBUF     12'h018
`define PPEI_OFF_THRESH    12'h01C
`define PPEI_OFF_PINS      12'h020

`define PPEI_MODE_NONE     2'h0
`define PPEI_MODE_RISE     2'h1
`define PPEI_MODE_FALL     2'h2
`define PPEI_MODE_BOTH     2'h3

`define PPEI_RST_MODE      16'h0000
`define PPEI_RST_STAT      8'h00
`define PPEI_RST_MASK      8'h00
`define PPEI_RST_INBUF     8'hFF
`define PPEI_RST_THRESH    2'h0

`endif

// >>> logic/ppei_sync.v
// two-stage synchroniser for a group of pin levels
`timescale 1ns/100ps
`default_nettype none

module ppei_sync #(
    parameter W = 8
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;
endmodule // ppei_sync

`default_nettype wire

// >>> logic/ppei_unit.v
// one port interrupt unit: eight pins, edge modes, sticky status, mask, wake
`timescale 1ns/100ps
`default_nettype none
`include "ppei_regs.vh"

module ppei_unit (
    input  wire        pclk,
    input  wire        presetn,
    input  wire [7:0]  pin_in,
    input  wire [7:0]  inbuf_en,
    input  wire [15:0] mode,
    input  wire [7:0]  mask,
    input  wire [7:0]  clr,
    output wire [7:0]  status,
    output wire [7:0]  pin_sync,
    output wire        irq,
    output wire        wake
);
    wire [7:0] gated;
    wire [7:0] s;
    reg  [7:0] prev_r;
    reg  [7:0] status_r;
    wire [7:0] hit;
    wire [7:0] armed;

    assign gated = pin_in & inbuf_en;

    ppei_sync #(.W(8)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (gated),
        .q       (s)
    );

    genvar i;
    generate
        for (i = 0; i < `PPEI_PINS; i = i + 1) begin : g_pin
            wire rise = s[i] & ~prev_r[i];
            wire fall = ~s[i] & prev_r[i];
            // per-pin mode decode, edges only
            assign hit[i] = (mode[2*i] & rise) | (mode[2*i+1] & fall);
            // clockless wake: unsynchronised armed pin level differs from last seen
            assign armed[i] = mode[2*i] | mode[2*i+1];
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r   <= 8'h00;
            status_r <= `PPEI_RST_STAT;
        end else begin
            prev_r   <= s;
            // set wins over clear, sticky until written
            status_r <= (status_r & ~clr) | hit;
        end
    end

    assign status   = status_r;
    assign pin_sync = s;
    assign irq      = |(status_r & mask);
    // combinational wake path needs no clock
    assign wake     = |((gated ^ prev_r) & armed & mask);
endmodule // ppei_unit

`default_nettype wire

// >>> logic/ppei_top.v
// port pin edge interrupt block: two ports with an apb register slave
// Operation
// - each pin selects rising, falling, both edges, or no interrupt
// - matching edge sets pin status bit and requests an interrupt
// - eight pins per port form one unit with its own interrupt vector
// - per-pin status register identifies which pin caused the request
// - edge detection and requests need pclk running; with the clock stopped only the wake path reacts
// - only edges are detected; level behaviour comes from configurable logic blocks
// - per-pin input buffer disable; per-port cmos or low voltage ttl threshold
// - a clockless wake path reacts to pin events in retention mode
`timescale 1ns/100ps
`default_nettype none
`include "ppei_regs.vh"

module ppei_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [7:0]  port0_pins,
    input  wire [7:0]  port1_pins,
    output reg         port0_irq,
    output reg         port1_irq,
    output reg  [1:0]  low_voltage_ttl_threshold,
    output wire        wake_req
);
    reg  [15:0] mode0_r;
    reg  [15:0] mode1_r;
    reg  [7:0]  mask0_r;
    reg  [7:0]  mask1_r;
    reg  [15:0] inbuf_r;
    reg  [1:0]  thresh_r;
    reg  [7:0]  clr0;
    reg  [7:0]  clr1;
    wire [7:0]  stat0;
    wire [7:0]  stat1;
    wire [7:0]  sync0;
    wire [7:0]  sync1;
    wire        irq0;
    wire        irq1;
    wire        wake0;
    wire        wake1;
    wire        setup;
    wire        wr;
    reg         hit_addr;

    assign setup = psel & ~penable;
    assign wr    = psel & penable & pready & pwrite;

    ppei_unit u_port0 (
        .pclk     (pclk),
        .presetn  (presetn),
        .pin_in   (port0_pins),
        .inbuf_en (inbuf_r[7:0]),
        .mode     (mode0_r),
        .mask     (mask0_r),
        .clr      (clr0),
        .status   (stat0),
        .pin_sync (sync0),
        .irq      (irq0),
        .wake     (wake0)
    );

    ppei_unit u_port1 (
        .pclk     (pclk),
        .presetn  (presetn),
        .pin_in   (port1_pins),
        .inbuf_en (inbuf_r[15:8]),
        .mode     (mode1_r),
        .mask     (mask1_r),
        .clr      (clr1),
        .status   (stat1),
        .pin_sync (sync1),
        .irq      (irq1),
        .wake     (wake1)
    );

    // wake path is combinational so it works with the clock stopped
    assign wake_req = wake0 | wake1;

    always @* begin
        case (paddr)
            `PPEI_OFF_MODE_LO,
            `PPEI_OFF_MODE_HI,
            `PPEI_OFF_STAT0,
            `PPEI_OFF_STAT1,
            `PPEI_OFF_MASK0,
            `PPEI_OFF_MASK1,
            `PPEI_OFF_INBUF,
            `PPEI_OFF_THRESH,
            `PPEI_OFF_PINS: hit_addr = 1'b1;
            default:        hit_addr = 1'b0;
        endcase
    end

    // write-one-to-clear of the sticky status bits
    always @* begin
        clr0 = 8'h00;
        clr1 = 8'h00;
        if (wr && paddr == `PPEI_OFF_STAT0) begin
            clr0 = pwdata[7:0];
        end
        if (wr && paddr == `PPEI_OFF_STAT1) begin
            clr1 = pwdata[7:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode0_r  <= `PPEI_RST_MODE;
            mode1_r  <= `PPEI_RST_MODE;
            mask0_r  <= `PPEI_RST_MASK;
            mask1_r  <= `PPEI_RST_MASK;
            inbuf_r  <= {`PPEI_RST_INBUF, `PPEI_RST_INBUF};
            thresh_r <= `PPEI_RST_THRESH;
        end else if (wr) begin
            case (paddr)
                `PPEI_OFF_MODE_LO: mode0_r  <= pwdata[15:0];
                `PPEI_OFF_MODE_HI: mode1_r  <= pwdata[15:0];
                `PPEI_OFF_MASK0:   mask0_r  <= pwdata[7:0];
                `PPEI_OFF_MASK1:   mask1_r  <= pwdata[7:0];
                `PPEI_OFF_INBUF:   inbuf_r  <= pwdata[15:0];
                `PPEI_OFF_THRESH:  thresh_r <= pwdata[1:0];
                default:           thresh_r <= thresh_r;
            endcase
        end
    end

    // apb: no wait states, answer in the first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (setup) begin
            pready  <= 1'b1;
            pslverr <= ~hit_addr;
            case (paddr)
                `PPEI_OFF_MODE_LO: prdata <= {16'h0000, mode0_r};
                `PPEI_OFF_MODE_HI: prdata <= {16'h0000, mode1_r};
                `PPEI_OFF_STAT0:   prdata <= {24'h000000, stat0};
                `PPEI_OFF_STAT1:   prdata <= {24'h000000, stat1};
                `PPEI_OFF_MASK0:   prdata <= {24'h000000, mask0_r};
                `PPEI_OFF_MASK1:   prdata <= {24'h000000, mask1_r};
                `PPEI_OFF_INBUF:   prdata <= {16'h0000, inbuf_r};
                `PPEI_OFF_THRESH:  prdata <= {30'h00000000, thresh_r};
                `PPEI_OFF_PINS:    prdata <= {16'h0000, sync1, sync0};
                default:           prdata <= 32'h00000000;
            endcase
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
    end

    // one vector per port, registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port0_irq                 <= 1'b0;
            port1_irq                 <= 1'b0;
            low_voltage_ttl_threshold <= `PPEI_RST_THRESH;
        end else begin
            port0_irq                 <= irq0;
            port1_irq                 <= irq1;
            low_voltage_ttl_threshold <= thresh_r;
        end
    end
endmodule // ppei_top

`default_nettype wire

// >>> tb/ppei_top_monitor.sv
// concurrent checks on the apb, threshold and interrupt ports
`timescale 1ns/100ps
`default_nettype none
module ppei_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        port0_irq,
    input wire logic        port1_irq,
    input wire logic [1:0]  low_voltage_ttl_threshold
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic wr_done = pready && pwrite;
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    decode_error_a: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h020))
        else $error("wrong decode error");
    // register takes the write at the access edge, the output flop one edge later
    thresh_write_a: assert property (wr_done && paddr == 12'h01C |-> ##2
        {30'h0, low_voltage_ttl_threshold} == ($past(pwdata, 2) & 32'h3))
        else $error("threshold not written");
    thresh_hold_a: assert property (!wr_done |-> ##2 $stable(low_voltage_ttl_threshold))
        else $error("threshold changed without write");
    irq_clear_cause_a: assert property ($fell(port0_irq) || $fell(port1_irq)
        |-> $past(wr_done, 2) || $past(wr_done)) else $error("irq fell without write");
endmodule // ppei_monitor
bind ppei_top ppei_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .port0_irq, .port1_irq, .low_voltage_ttl_threshold);
`default_nettype wire

// >>> tb/ppei_pin_model.sv
// external pin source and interrupt request counter at the far side
`timescale 1ns/100ps
`default_nettype none
module ppei_pin_model (
    input  wire logic       pclk,
    input  wire logic [7:0] lvl0,
    input  wire logic [7:0] lvl1,
    input  wire logic       irq0,
    output var  logic [7:0] port0_pins,
    output var  logic [7:0] port1_pins,
    output var  int         irq0_cnt
);
    logic irq0_d;
    initial begin
        port0_pins = 8'h00;
        port1_pins = 8'h00;
        irq0_cnt = 0;
    end
    always @(posedge pclk) begin
        port0_pins <= lvl0;
        port1_pins <= lvl1;
        irq0_d <= irq0;
        if (irq0 && !irq0_d) irq0_cnt <= irq0_cnt + 1;
    end
endmodule // ppei_pin_model
`default_nettype wire

// >>> tb/ppei_top_tb.sv
// register and pin event tests of the edge interrupt block
`timescale 1ns/100ps
`default_nettype none
module ppei_top_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [7:0]  p0, p1, lvl0 = 0, lvl1 = 0;
    logic        irq0, irq1, wake, er;
    logic [1:0]  thr;
    int          err_count = 0, num_checks = 0, ic, m;
    always #2.5 pclk = ~pclk;
    ppei_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .port0_pins(p0), .port1_pins(p1), .port0_irq(irq0),
        .port1_irq(irq1), .low_voltage_ttl_threshold(thr), .wake_req(wake));
    ppei_pin_model u_pins (.pclk, .lvl0, .lvl1, .irq0, .port0_pins(p0), .port1_pins(p1),
        .irq0_cnt(ic));
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] e, input string n);
        apb(0, a, 0);
        chk(n, rd, e);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task settle;
        repeat (8) @(posedge pclk);
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        conclude;
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        rchk(12'h000, 0, "mode0 reset");
        rchk(12'h018, 32'h0000FFFF, "inbuf reset");
        rchk(12'h040, 0, "unmapped read");
        chk("unmapped err", er, 1);
        apb(1, 12'h01C, 3);
        rchk(12'h01C, 3, "threshold reg");
        chk("threshold port", thr, 2'h3);
        $display("test registers done");
        for (m = 0; m < 4; m++) begin
            apb(1, 12'h000, m);
            apb(1, 12'h008, 32'hFF);
            lvl0 <= 8'h01;
            settle;
            rchk(12'h008, m & 1, "rise status");
            apb(1, 12'h008, 32'hFF);
            lvl0 <= 8'h00;
            settle;
            rchk(12'h008, m >> 1, "fall status");
            apb(1, 12'h008, 32'hFF);
        end
        $display("test modes done");
        apb(1, 12'h000, 3);
        apb(1, 12'h010, 1);
        apb(1, 12'h004, 32'h0C00);
        lvl0 <= 8'h01;
        lvl1 <= 8'h20;
        settle;
        chk("port0 irq", irq0, 1);
        chk("port1 irq masked", irq1, 0);
        rchk(12'h00C, 32'h20, "port1 status pin");
        repeat (20) @(posedge pclk);
        chk("irq requests", ic, 1);
        rchk(12'h008, 1, "status sticky");
        apb(1, 12'h008, 1);
        repeat (3) @(posedge pclk);
        chk("irq cleared", irq0, 0);
        $display("test irq done");
        apb(1, 12'h018, 32'hFFFE);
        settle;
        apb(0, 12'h020, 0);
        chk("disabled pin", rd[7:0], 8'h00);
        apb(1, 12'h000, 7);
        apb(1, 12'h010, 3);
        apb(1, 12'h008, 32'hFF);
        settle;
        lvl0 <= 8'h03;
        @(posedge pclk);
        #1 chk("wake request", wake, 1);
        settle;
        chk("wake released", wake, 0);
        rchk(12'h008, 32'h02, "disabled pin no edge");
        $display("test wake done");
        conclude;
    end
endmodule // ppei_top_tb
`default_nettype wire
